// *** include/psfs_consts.vh ***
`ifndef PSFS_CONSTS_VH
`define PSFS_CONSTS_VH
`define PSFS_A_CFG      8'h00
`define PSFS_A_FLT      8'h04
`define PSFS_A_MASKA    8'h08
`define PSFS_A_MASKB    8'h0C
`define PSFS_A_MASKSD   8'h10
`define PSFS_A_PIN      8'h14
`define PSFS_A_RETRY    8'h18
`define PSFS_A_LL       8'h1C
`define PSFS_A_TRANS    8'h20
`define PSFS_A_OC       8'h24
`define PSFS_A_TEMP     8'h28
`define PSFS_A_VOLT     8'h2C
`define PSFS_A_BAL      8'h30
`define PSFS_A_TIME     8'h34
`define PSFS_A_ISUM     8'h38
`define PSFS_A_STATE    8'h3C
`define PSFS_NFLT       11
`define PSFS_F_IUV      0
`define PSFS_F_OOV      1
`define PSFS_F_OUV      2
`define PSFS_F_POC      3
`define PSFS_F_TOC      4
`define PSFS_F_ITA      5
`define PSFS_F_ITS      6
`define PSFS_F_ETA      7
`define PSFS_F_ETS      8
`define PSFS_F_CRC      9
`define PSFS_F_CAL      10
`define PSFS_RST_CFG    32'h000000C6
`define PSFS_RST_MASK   32'h000007FF
`define PSFS_RST_PIN    32'h00000000
`define PSFS_RST_RETRY  32'h00001000
`define PSFS_RST_LL     32'h00000400
`define PSFS_RST_TRANS  32'h00302010
`define PSFS_RST_OC     32'h00F0C0A0
`define PSFS_RST_TEMP   32'h00003228
`define PSFS_RST_VOLT   32'h00104020
`define PSFS_RST_TIME   32'h00800010
`endif

// *** src/psfs_top.v ***
`include "psfs_consts.vh"
`default_nettype none
module psfs_top #(
  parameter CW = 12,
  parameter VW = 10
) (
  // Clock and reset.
  input  wire                clock_i,
  input  wire                nrst_i,
  // APB slave.
  input  wire                psel_i,
  input  wire                penable_i,
  input  wire                pwrite_i,
  input  wire [7:0]          paddr_i,
  input  wire [31:0]         pwdata_i,
  output wire [31:0]         prdata_o,
  output wire                pready_o,
  output wire                pslverr_o,
  // Sequencing inputs.
  input  wire                regulator_enable_in_i,
  input  wire                nv_load_done_i,
  input  wire                nv_crc_match_i,
  input  wire                cal_target_met_i,
  input  wire                soft_start_done_i,
  input  wire [7:0]          duty_i,
  // Sensed values from the converters.
  input  wire [VW-1:0]       supply_sense_in_i,
  input  wire [VW-1:0]       output_sense_in_i,
  input  wire [VW-1:0]       voltage_code_i,
  input  wire [6*CW-1:0]     phase_current_sense_in_i,
  input  wire [5:0]          temp_int_i,
  input  wire [5:0]          temp_ext_i,
  // Three-level phase outputs.
  output reg  [5:0]          phase_out_o,
  output reg  [5:0]          phase_oe_o,
  // Alarm pins.
  output reg                 alarm_pin_a_o,
  output reg                 alarm_pin_a_oe_o,
  output reg                 alarm_pin_b_o,
  output reg                 alarm_pin_b_oe_o,
  // Loop adjustments.
  output reg  [4:0]          load_line_offset_o,
  output reg                 load_line_steep_o,
  output reg  [CW+2:0]       isum_filt_o,
  output reg  [6*(CW+3)-1:0] balance_trim_o
);
  localparam [2:0] ST_LOAD = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_CAL  = 3'h2;
  localparam [2:0] ST_SS   = 3'h3;
  localparam [2:0] ST_REG  = 3'h4;
  localparam [2:0] ST_WAIT = 3'h5;
  localparam [2:0] ST_HALT = 3'h6;

  // Phase fired in slot k for a given phase count.
  function [2:0] fire_idx;
    input [2:0] n;
    input [2:0] k;
    begin
      if (n < 3'h4) begin
        fire_idx = k;
      end else begin
        case (k)
          3'h0: fire_idx = 3'h0;
          3'h1: fire_idx = 3'h3;
          3'h2: fire_idx = 3'h1;
          3'h3: fire_idx = (n == 3'h4) ? 3'h2 : 3'h4;
          3'h4: fire_idx = 3'h2;
          default: fire_idx = 3'h5;
        endcase
      end
    end
  endfunction

  reg  [31:0] cfg;
  reg  [31:0] mask_a;
  reg  [31:0] mask_b;
  reg  [31:0] mask_sd;
  reg  [31:0] pin_cfg;
  reg  [31:0] retry_dly;
  reg  [31:0] ll_cfg;
  reg  [31:0] trans_cfg;
  reg  [31:0] oc_cfg;
  reg  [31:0] temp_cfg;
  reg  [31:0] volt_cfg;
  reg  [31:0] bal_cfg;
  reg  [31:0] time_cfg;
  reg  [`PSFS_NFLT-1:0] flt_latch;
  reg  [`PSFS_NFLT-1:0] flt_live;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [31:0] timer;
  reg         sd_latched;
  reg  [2:0]  en_sync;
  reg         en_q;
  reg  [31:0] rdata;
  reg         cal_timeout;
  reg  [15:0] slot_cnt;
  reg  [2:0]  slot;
  reg  [5:0]  oc_pend;
  reg  [5:0]  oc_skip;
  reg  [CW+2:0] isum;
  reg  [CW+2:0] avg;
  reg  [1:0]  engage;
  reg  [VW-1:0] err;
  reg         over;
  reg  [5:0]  assist;
  reg  [5:0]  next_out;
  reg  [5:0]  next_oe;
  reg  [CW-1:0] ich;
  reg  [CW+2:0] trim;
  reg  [4:0]  boff;
  reg         sd_hit;
  reg         alarm_a;
  reg         alarm_b;
  reg  [6*(CW+3)-1:0] next_trim;
  integer     i;
  integer     ia;
  integer     io;
  integer     ip;
  integer     ib;
  integer     il;

  wire        wr_en     = psel_i & penable_i & pwrite_i;
  wire [2:0]  nph_raw   = (cfg[2:0] < 3'h2) ? 3'h2 : ((cfg[2:0] > 3'h6) ? 3'h6 : cfg[2:0]);
  wire        dis_mode  = cfg[3];
  wire [2:0]  nph       = (dis_mode && nph_raw == 3'h6) ? 3'h5 : nph_raw;
  wire        rec_latch = cfg[4];
  wire        iuv_sd    = cfg[5];
  wire        int_asst  = cfg[6];
  wire        ext_asst  = cfg[7];
  wire        en_lvl    = en_q;
  wire        active    = (state == ST_CAL) || (state == ST_SS) || (state == ST_REG);
  wire        regulating = (state == ST_REG);
  wire [2:0]  slot_nx   = (slot + 3'h1 >= nph) ? 3'h0 : slot + 3'h1;
  wire [2:0]  slot_ph   = fire_idx(nph, slot_nx);
  wire [2:0]  cur_ph    = fire_idx(nph, slot);

  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o  = rdata;

  // Three-stage input capture of the enable pin; a change counts once stages two and three agree.
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_sync <= 3'h0;
      en_q    <= 1'b0;
    end else begin
      en_sync <= {en_sync[1:0], regulator_enable_in_i};
      if (en_sync[2] == en_sync[1]) begin
        en_q <= en_sync[2];
      end
    end
  end

  // Live fault conditions from the comparators.
  always @* begin
    flt_live = {`PSFS_NFLT{1'b0}};
    flt_live[`PSFS_F_IUV] = supply_sense_in_i < volt_cfg[VW-1:0];
    flt_live[`PSFS_F_OOV] = (state == ST_SS || regulating) &&
                            (output_sense_in_i > voltage_code_i + volt_cfg[23:16]);
    flt_live[`PSFS_F_OUV] = regulating && (output_sense_in_i < volt_cfg[VW+7:8]);
    for (il = 0; il < 6; il = il + 1) begin
      if (phase_current_sense_in_i[il*CW +: CW] > {oc_cfg[7:0], {(CW-8){1'b0}}}) begin
        flt_live[`PSFS_F_POC] = 1'b1;
      end
    end
    flt_live[`PSFS_F_TOC] = isum_filt_o > {oc_cfg[23:16], 7'h00};
    flt_live[`PSFS_F_ITA] = temp_int_i >= temp_cfg[5:0];
    flt_live[`PSFS_F_ITS] = temp_int_i >= temp_cfg[13:8];
    flt_live[`PSFS_F_ETA] = temp_ext_i >= temp_cfg[5:0];
    flt_live[`PSFS_F_ETS] = temp_ext_i >= temp_cfg[13:8];
    flt_live[`PSFS_F_CRC] = nv_load_done_i && !nv_crc_match_i;
    flt_live[`PSFS_F_CAL] = cal_timeout;
  end

  // Input undervoltage forces shutdown only when so configured.
  always @* begin
    sd_hit = |(flt_live & mask_sd[`PSFS_NFLT-1:0] & ~(`PSFS_NFLT'h1 << `PSFS_F_IUV));
    if (iuv_sd && regulating && mask_sd[`PSFS_F_IUV] && flt_live[`PSFS_F_IUV]) begin
      sd_hit = 1'b1;
    end
  end

  // Regulator sequencing.
  always @* begin
    next_state = state;
    case (state)
      ST_LOAD: begin
        if (nv_load_done_i) begin
          next_state = nv_crc_match_i ? ST_IDLE : ST_HALT;
        end
      end
      ST_IDLE: begin
        if (en_lvl && !sd_latched && !flt_live[`PSFS_F_IUV]) begin
          next_state = ST_CAL;
        end
      end
      ST_CAL: begin
        if (!en_lvl || sd_hit || cal_timeout) begin
          next_state = ST_WAIT;
        end else if (cal_target_met_i) begin
          next_state = ST_SS;
        end
      end
      ST_SS: begin
        if (!en_lvl || sd_hit) begin
          next_state = ST_WAIT;
        end else if (soft_start_done_i) begin
          next_state = ST_REG;
        end
      end
      ST_REG: begin
        if (!en_lvl || sd_hit) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (timer >= retry_dly) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state       <= ST_LOAD;
      timer       <= 32'h00000000;
      sd_latched  <= 1'b0;
      cal_timeout <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        timer <= 32'h00000000;
      end else begin
        timer <= timer + 32'h00000001;
      end
      cal_timeout <= (state == ST_CAL) && (timer >= {16'h0000, time_cfg[31:16]});
      if (!en_lvl) begin
        sd_latched <= 1'b0;
      end else if (active && sd_hit && rec_latch) begin
        sd_latched <= 1'b1;
      end
    end
  end

  // Fault latch: hardware set wins over a write-one-to-clear in the same cycle.
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flt_latch <= {`PSFS_NFLT{1'b0}};
    end else if (wr_en && paddr_i == `PSFS_A_FLT) begin
      flt_latch <= (flt_latch & ~pwdata_i[`PSFS_NFLT-1:0]) | flt_live;
    end else begin
      flt_latch <= flt_latch | flt_live;
    end
  end

  // Register writes.
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg       <= `PSFS_RST_CFG;
      mask_a    <= `PSFS_RST_MASK;
      mask_b    <= `PSFS_RST_MASK;
      mask_sd   <= `PSFS_RST_MASK;
      pin_cfg   <= `PSFS_RST_PIN;
      retry_dly <= `PSFS_RST_RETRY;
      ll_cfg    <= `PSFS_RST_LL;
      trans_cfg <= `PSFS_RST_TRANS;
      oc_cfg    <= `PSFS_RST_OC;
      temp_cfg  <= `PSFS_RST_TEMP;
      volt_cfg  <= `PSFS_RST_VOLT;
      bal_cfg   <= 32'h00000000;
      time_cfg  <= `PSFS_RST_TIME;
    end else if (wr_en) begin
      if (paddr_i == `PSFS_A_CFG) begin
        cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_MASKA) begin
        mask_a <= pwdata_i;
      end else if (paddr_i == `PSFS_A_MASKB) begin
        mask_b <= pwdata_i;
      end else if (paddr_i == `PSFS_A_MASKSD) begin
        mask_sd <= pwdata_i;
      end else if (paddr_i == `PSFS_A_PIN) begin
        pin_cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_RETRY) begin
        retry_dly <= pwdata_i;
      end else if (paddr_i == `PSFS_A_LL) begin
        ll_cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_TRANS) begin
        trans_cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_OC) begin
        oc_cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_TEMP) begin
        temp_cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_VOLT) begin
        volt_cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_BAL) begin
        bal_cfg <= pwdata_i;
      end else if (paddr_i == `PSFS_A_TIME) begin
        time_cfg <= pwdata_i;
      end
    end
  end

  // Register reads; unmapped addresses read zero.
  always @* begin
    rdata = 32'h00000000;
    if (paddr_i == `PSFS_A_CFG) begin
      rdata = cfg;
    end else if (paddr_i == `PSFS_A_FLT) begin
      rdata = {21'h000000, flt_latch};
    end else if (paddr_i == `PSFS_A_MASKA) begin
      rdata = mask_a;
    end else if (paddr_i == `PSFS_A_MASKB) begin
      rdata = mask_b;
    end else if (paddr_i == `PSFS_A_MASKSD) begin
      rdata = mask_sd;
    end else if (paddr_i == `PSFS_A_PIN) begin
      rdata = pin_cfg;
    end else if (paddr_i == `PSFS_A_RETRY) begin
      rdata = retry_dly;
    end else if (paddr_i == `PSFS_A_LL) begin
      rdata = ll_cfg;
    end else if (paddr_i == `PSFS_A_TRANS) begin
      rdata = trans_cfg;
    end else if (paddr_i == `PSFS_A_OC) begin
      rdata = oc_cfg;
    end else if (paddr_i == `PSFS_A_TEMP) begin
      rdata = temp_cfg;
    end else if (paddr_i == `PSFS_A_VOLT) begin
      rdata = volt_cfg;
    end else if (paddr_i == `PSFS_A_BAL) begin
      rdata = bal_cfg;
    end else if (paddr_i == `PSFS_A_TIME) begin
      rdata = time_cfg;
    end else if (paddr_i == `PSFS_A_ISUM) begin
      rdata = {{(32-CW-3){1'b0}}, isum_filt_o};
    end else if (paddr_i == `PSFS_A_STATE) begin
      rdata = {27'h0000000, sd_latched, en_lvl, state};
    end
  end

  // Current sum and average over the active phases.
  always @* begin
    isum = {(CW+3){1'b0}};
    for (i = 0; i < 6; i = i + 1) begin
      if (i < nph) begin
        isum = isum + {3'h0, phase_current_sense_in_i[i*CW +: CW]};
      end
    end
    avg = isum / {{(CW){1'b0}}, nph};
  end

  // Window comparators on the output error.
  always @* begin
    over = output_sense_in_i > voltage_code_i;
    err  = over ? (output_sense_in_i - voltage_code_i) : (voltage_code_i - output_sense_in_i);
    engage = {1'b0, err > {2'h0, trans_cfg[7:0]}} + {1'b0, err > {2'h0, trans_cfg[15:8]}} +
             {1'b0, err > {2'h0, trans_cfg[23:16]}};
    assist = 6'h00;
    for (ia = 0; ia < 3; ia = ia + 1) begin
      if (int_asst && ia < engage && ia < nph) begin
        assist[fire_idx(nph, ia[2:0])] = 1'b1;
      end
    end
  end

  // Slot timing, rotation and per-phase overcurrent blanking.
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_cnt <= 16'h0000;
      slot     <= 3'h0;
      oc_pend  <= 6'h00;
      oc_skip  <= 6'h00;
    end else if (!active) begin
      slot_cnt <= 16'h0000;
      slot     <= 3'h0;
      oc_pend  <= 6'h00;
      oc_skip  <= 6'h00;
    end else begin
      if (slot_cnt >= time_cfg[15:0]) begin
        slot_cnt <= 16'h0000;
        slot <= slot_nx;
        oc_skip[slot_ph] <= oc_pend[slot_ph];
        oc_pend[slot_ph] <= 1'b0;
      end else begin
        slot_cnt <= slot_cnt + 16'h0001;
      end
      // A channel still over its limit sets again over the slot clear.
      for (io = 0; io < 6; io = io + 1) begin
        if (phase_current_sense_in_i[io*CW +: CW] > {oc_cfg[7:0], {(CW-8){1'b0}}}) begin
          oc_pend[io] <= 1'b1;
        end
      end
    end
  end

  // Phase pin levels: high turns the high side on, low the low side, floating neither.
  always @* begin
    next_out = 6'h00;
    next_oe  = 6'h00;
    if (active) begin
      for (ip = 0; ip < 6; ip = ip + 1) begin
        if (ip < nph) begin
          next_oe[ip] = 1'b1;
          next_out[ip] = (ip == cur_ph) && !oc_skip[ip] && (slot_cnt < {8'h00, duty_i});
          if (assist[ip]) begin
            next_out[ip] = !over;
          end
        end
      end
      if (dis_mode) begin
        next_oe[5]  = 1'b1;
        next_out[5] = ext_asst && over && (err > {2'h0, trans_cfg[7:0]});
      end
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_out_o <= 6'h00;
      phase_oe_o  <= 6'h00;
    end else begin
      phase_out_o <= next_out;
      phase_oe_o  <= next_oe;
    end
  end

  // Alarm pins: live OR of unmasked faults, or the latched flags.
  always @* begin
    alarm_a = pin_cfg[0] ? |(flt_latch & mask_a[`PSFS_NFLT-1:0]) : |(flt_live & mask_a[`PSFS_NFLT-1:0]);
    alarm_b = pin_cfg[4] ? |(flt_latch & mask_b[`PSFS_NFLT-1:0]) : |(flt_live & mask_b[`PSFS_NFLT-1:0]);
  end

  // Per-channel balance targets.
  always @* begin
    next_trim = {(6*(CW+3)){1'b0}};
    ich  = {CW{1'b0}};
    boff = 5'h00;
    trim = {(CW+3){1'b0}};
    for (ib = 0; ib < 6; ib = ib + 1) begin
      ich  = phase_current_sense_in_i[ib*CW +: CW];
      boff = bal_cfg[ib*5 +: 5];
      trim = avg - {3'h0, ich} + {{(CW-2){boff[4]}}, boff};
      if (ib < nph) begin
        next_trim[ib*(CW+3) +: (CW+3)] = trim;
      end
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_pin_a_o      <= 1'b0;
      alarm_pin_a_oe_o   <= 1'b0;
      alarm_pin_b_o      <= 1'b0;
      alarm_pin_b_oe_o   <= 1'b0;
      load_line_offset_o <= 5'h00;
      load_line_steep_o  <= 1'b0;
      isum_filt_o        <= {(CW+3){1'b0}};
      balance_trim_o     <= {(6*(CW+3)){1'b0}};
    end else begin
      alarm_pin_a_o    <= pin_cfg[2] ? 1'b0 : (alarm_a ^ pin_cfg[1]);
      alarm_pin_a_oe_o <= pin_cfg[2] ? (alarm_a ^ ~pin_cfg[1]) : 1'b1;
      alarm_pin_b_o    <= pin_cfg[6] ? 1'b0 : (alarm_b ^ pin_cfg[5]);
      alarm_pin_b_oe_o <= pin_cfg[6] ? (alarm_b ^ ~pin_cfg[5]) : 1'b1;
      load_line_offset_o <= ll_cfg[4:0];
      load_line_steep_o  <= isum_filt_o > {oc_cfg[15:8], 7'h00};
      if (isum >= isum_filt_o) begin
        isum_filt_o <= isum_filt_o + ((isum - isum_filt_o) >> ll_cfg[11:8]);
      end else begin
        isum_filt_o <= isum_filt_o - ((isum_filt_o - isum) >> ll_cfg[11:8]);
      end
      balance_trim_o <= next_trim;
    end
  end
endmodule
`default_nettype wire

// *** verif/psfs_gate_model.sv ***
`default_nettype none
module psfs_gate_model (
  // Phase drive from the controller.
  input  wire logic [5:0] drv_in_i,
  input  wire logic [5:0] drv_oe_i,
  // Switch states of the power stages.
  output wire logic [5:0] hs_on_o,
  output wire logic [5:0] ls_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating input rests between the thresholds, so neither switch turns on.
  assign hs_on_o = drv_oe_i & drv_in_i;
  assign ls_on_o = drv_oe_i & ~drv_in_i;
endmodule
`default_nettype wire

// *** verif/psfs_properties.sv ***
`include "psfs_consts.vh"
`default_nettype none
module psfs_checker #(
  parameter CW = 12
) (
  // Clock, reset and register bus.
  input wire logic          clock_i,
  input wire logic          nrst_i,
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic          pwrite_i,
  input wire logic [7:0]    paddr_i,
  input wire logic [31:0]   pwdata_i,
  input wire logic [31:0]   prdata_o,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  // Enable pin and observed outputs.
  input wire logic          regulator_enable_in_i,
  input wire logic [5:0]    phase_oe_o,
  input wire logic          alarm_pin_a_o,
  input wire logic          alarm_pin_a_oe_o,
  input wire logic          alarm_pin_b_oe_o,
  input wire logic [4:0]    load_line_offset_o,
  input wire logic          load_line_steep_o,
  input wire logic [CW+2:0] isum_filt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  age;
  logic [31:0] pin_q;
  logic [31:0] ll_q;
  logic [31:0] oc_q;
  wire         wr = psel_i && penable_i && pwrite_i && pready_o;
  wire         quiet = (age == 2'h3);
  wire [CW+2:0] th = (CW+3)'({oc_q[15:8], 7'h00});
  // Shadow copies of the settings that the outputs follow; age counts cycles since a write.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      age <= 2'h0;
      pin_q <= `PSFS_RST_PIN;
      ll_q <= `PSFS_RST_LL;
      oc_q <= `PSFS_RST_OC;
    end else begin
      age <= wr ? 2'h0 : (quiet ? age : age + 2'h1);
      pin_q <= (wr && paddr_i == `PSFS_A_PIN) ? pwdata_i : pin_q;
      ll_q <= (wr && paddr_i == `PSFS_A_LL) ? pwdata_i : ll_q;
      oc_q <= (wr && paddr_i == `PSFS_A_OC) ? pwdata_i : oc_q;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  zero_wait_a: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
    else $error("bus access not answered at once");
  unmapped_zero_a: assert property (psel_i && penable_i && !pwrite_i && paddr_i >= 8'h40 |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  release_float_a: assert property ($rose(nrst_i) |-> phase_oe_o == 6'h00)
    else $error("phase driven at reset release");
  disabled_float_a: assert property (!regulator_enable_in_i [*8] |-> phase_oe_o == 6'h00)
    else $error("phase driven while disabled");
  offset_copy_a: assert property (quiet |-> load_line_offset_o == ll_q[4:0])
    else $error("offset output differs from setting");
  steep_set_a: assert property ((quiet && isum_filt_o > th) [*3] |-> load_line_steep_o)
    else $error("steep slope missing");
  steep_clear_a: assert property ((quiet && isum_filt_o <= th) [*3] |-> !load_line_steep_o)
    else $error("steep slope without cause");
  od_never_high_a: assert property (quiet && pin_q[2] |-> !alarm_pin_a_o)
    else $error("open drain pin driven high");
  pp_a_drives_a: assert property (quiet && !pin_q[2] |-> alarm_pin_a_oe_o)
    else $error("push pull pin a not driven");
  pp_b_drives_a: assert property (quiet && !pin_q[6] |-> alarm_pin_b_oe_o)
    else $error("push pull pin b not driven");
  steep_seen_c: cover property (load_line_steep_o);
  alarm_seen_c: cover property (alarm_pin_a_o && alarm_pin_a_oe_o);
  phase_run_c: cover property (phase_oe_o != 6'h00);
endmodule
bind psfs_top psfs_checker #(.CW(CW)) chk_u (.*);
`default_nettype wire

// *** verif/psfs_top_test.sv ***
`include "psfs_consts.vh"
`default_nettype none
module psfs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i;
  logic        nrst_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        regulator_enable_in_i = 1'b0;
  logic        nv_load_done_i = 1'b0;
  logic        nv_crc_match_i = 1'b1;
  logic        cal_target_met_i = 1'b1;
  logic        soft_start_done_i = 1'b1;
  logic [7:0]  duty_i = 8'h03;
  logic [9:0]  supply_sense_in_i = 10'h3FF;
  logic [9:0]  output_sense_in_i = 10'h0C8;
  logic [9:0]  voltage_code_i = 10'h0C8;
  logic [71:0] phase_current_sense_in_i = {6{12'h010}};
  logic [5:0]  temp_int_i = 6'h00;
  logic [5:0]  temp_ext_i = 6'h00;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, alarm_pin_a_o, alarm_pin_a_oe_o, alarm_pin_b_o, alarm_pin_b_oe_o;
  wire         load_line_steep_o;
  wire  [5:0]  phase_out_o, phase_oe_o, hs_on, ls_on;
  wire  [4:0]  load_line_offset_o;
  wire  [14:0] isum_filt_o;
  wire  [89:0] trim_w;
  logic [5:0]  hs_prev;
  logic [3:0]  fired[$];
  logic [23:0] seqs[2:6] = '{24'h12, 24'h123, 24'h1423, 24'h14253, 24'h142536};
  logic [5:0]  ae[1:3] = '{6'h01, 6'h09, 6'h0B};
  int          failures = 0;
  int          check_count = 0;
  int          c;
  psfs_top dut_u (.balance_trim_o(trim_w), .*);
  psfs_gate_model gm_u (.drv_in_i(phase_out_o), .drv_oe_i(phase_oe_o), .hs_on_o(hs_on), .ls_on_o(ls_on));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Log each phase as its high-side switch turns on.
  always @(posedge clock_i) begin
    hs_prev <= hs_on;
    for (int i = 0; i < 6; i++)
      if (hs_on[i] && !hs_prev[i])
        fired.push_back(4'(i + 1));
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic cmp(input logic [31:0] exp, input logic [31:0] act);
    check_count++;
    if (act !== exp) begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      q = prdata_o;
    end while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    cmp(exp, q);
  endtask
  task automatic load(input logic crc);
    nv_crc_match_i <= crc;
    nv_load_done_i <= 1'b1;
    tick(1);
    nv_load_done_i <= 1'b0;
  endtask
  task automatic order(input int n, input logic [23:0] s);
    int k;
    wr(`PSFS_A_CFG, 32'(n));
    regulator_enable_in_i <= 1'b1;
    tick(40);
    fired.delete();
    tick(24 * n + 8);
    k = 0;
    while (k < n && fired[k] != 4'h1) k++;
    for (int j = 0; j < 2 * n; j++)
      cmp(s[4 * ((n - 1) - j % n) +: 4], fired[k + j]);
    regulator_enable_in_i <= 1'b0;
    tick(30);
    cmp(6'h00, phase_oe_o);
  endtask
  task automatic oc_set(input logic hi);
    phase_current_sense_in_i[11:0] <= hi ? 12'hB00 : 12'h010;
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    complete_run();
  end
  initial begin
    tick(6);
    nrst_i <= 1'b1;
    rd(`PSFS_A_CFG, `PSFS_RST_CFG);
    rd(`PSFS_A_MASKA, `PSFS_RST_MASK);
    rd(`PSFS_A_MASKB, `PSFS_RST_MASK);
    rd(`PSFS_A_MASKSD, `PSFS_RST_MASK);
    rd(`PSFS_A_PIN, `PSFS_RST_PIN);
    rd(`PSFS_A_RETRY, `PSFS_RST_RETRY);
    rd(`PSFS_A_LL, `PSFS_RST_LL);
    rd(`PSFS_A_TRANS, `PSFS_RST_TRANS);
    rd(`PSFS_A_OC, `PSFS_RST_OC);
    rd(`PSFS_A_TEMP, `PSFS_RST_TEMP);
    rd(`PSFS_A_VOLT, `PSFS_RST_VOLT);
    rd(`PSFS_A_TIME, `PSFS_RST_TIME);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    cmp(6'h00, phase_oe_o);
    load(1'b0);
    regulator_enable_in_i <= 1'b1;
    tick(40);
    cmp(6'h00, phase_oe_o);
    regulator_enable_in_i <= 1'b0;
    nrst_i <= 1'b0;
    tick(6);
    nrst_i <= 1'b1;
    wr(`PSFS_A_RETRY, 32'h8);
    wr(`PSFS_A_TIME, 32'h01000007);
    wr(`PSFS_A_OC, 32'h00F001A0);
    wr(`PSFS_A_LL, 32'h0000041F);
    wr(`PSFS_A_MASKSD, 32'h7F7);
    wr(`PSFS_A_MASKA, 32'h8);
    wr(`PSFS_A_MASKB, 32'h4);
    load(1'b1);
    for (int n = 2; n <= 6; n++)
      order(n, seqs[n]);
    wr(`PSFS_A_CFG, 32'h2);
    wr(`PSFS_A_FLT, 32'h7FF);
    regulator_enable_in_i <= 1'b1;
    tick(40);
    cmp(1'h0, alarm_pin_a_o);
    oc_set(1'b1);
    tick(10);
    fired.delete();
    tick(48);
    c = 0;
    foreach (fired[i]) c += (fired[i] == 4'h1);
    cmp(32'h0, c);
    cmp(1'h1, fired.size() > 0);
    cmp(1'h1, phase_oe_o[0]);
    cmp(1'h1, alarm_pin_a_o);
    cmp(1'h0, alarm_pin_b_o);
    rd(`PSFS_A_FLT, 32'h8);
    oc_set(1'b0);
    tick(10);
    cmp(1'h0, alarm_pin_a_o);
    rd(`PSFS_A_FLT, 32'h8);
    wr(`PSFS_A_PIN, 32'h1);
    tick(3);
    cmp(1'h1, alarm_pin_a_o);
    wr(`PSFS_A_FLT, 32'h8);
    tick(3);
    cmp(1'h0, alarm_pin_a_o);
    rd(`PSFS_A_FLT, 32'h0);
    wr(`PSFS_A_PIN, 32'h6);
    tick(3);
    cmp(1'h0, alarm_pin_a_oe_o);
    wr(`PSFS_A_PIN, 32'h2);
    tick(3);
    cmp(1'h1, alarm_pin_a_o);
    wr(`PSFS_A_MASKSD, 32'h7FF);
    wr(`PSFS_A_CFG, 32'h12);
    oc_set(1'b1);
    tick(6);
    cmp(6'h00, phase_oe_o);
    oc_set(1'b0);
    tick(60);
    cmp(6'h00, phase_oe_o);
    regulator_enable_in_i <= 1'b0;
    tick(10);
    regulator_enable_in_i <= 1'b1;
    tick(40);
    cmp(2'h3, phase_oe_o[1:0]);
    wr(`PSFS_A_CFG, 32'h2);
    oc_set(1'b1);
    tick(6);
    cmp(6'h00, phase_oe_o);
    oc_set(1'b0);
    tick(60);
    cmp(2'h3, phase_oe_o[1:0]);
    wr(`PSFS_A_CFG, 32'h44);
    duty_i <= 8'h00;
    tick(40);
    for (int j = 1; j <= 3; j++) begin
      output_sense_in_i <= 10'h0C0 - 10'(16 * j);
      tick(6);
      cmp(ae[j], hs_on);
    end
    wr(`PSFS_A_VOLT, 32'h003C4020);
    wr(`PSFS_A_CFG, 32'h8E);
    output_sense_in_i <= 10'h0E0;
    tick(6);
    cmp(1'h1, hs_on[5]);
    output_sense_in_i <= 10'h0B0;
    tick(6);
    cmp(1'h0, hs_on[5]);
    wr(`PSFS_A_BAL, 32'h3);
    tick(3);
    cmp(32'h3, trim_w[14:0]);
    cmp(32'h0, trim_w[89:75]);
    complete_run();
  end
endmodule
`default_nettype wire
